// File: hw/eit_cfg.svh
// Constants for the exception entry unit: vectors, status field positions, pc steps
`ifndef EIT_CFG_SVH
`define EIT_CFG_SVH

// Vector entries in user space
`define EIT_VEC_RESET 32'h0000_0000
`define EIT_VEC_SBREAK 32'h0000_0010
`define EIT_VEC_UNDEF 32'h0000_0020
`define EIT_VEC_MISALIGN 32'h0000_0030
`define EIT_VEC_TRAP_BASE 32'h0000_0040
`define EIT_VEC_TRAP_LAST 32'h0000_007c
`define EIT_VEC_PIRQ 32'h0000_0080
`define EIT_VEC_RAM 32'h0080_4000

// Address arithmetic
`define EIT_TRAP_STEP 32'h0000_0004
`define EIT_WORD_LSB 2'h0
`define EIT_TRAP_PAD 26'h000_0000

// Processor status field positions
`define EIT_PSW_W 16
`define EIT_PSW_C 0
`define EIT_PSW_IE 6
`define EIT_PSW_SM 7
`define EIT_PSW_BC 8
`define EIT_PSW_BIE 14
`define EIT_PSW_BSM 15

// Reset values
`define EIT_RST_SYNC 2'h0
`define EIT_RST_PC 32'h0000_0000

`endif

// File: hw/eit_pkg.sv
// Types and shared functions of the exception entry unit
`include "eit_cfg.svh"
package eit_pkg;

	// Sequencer states, Gray along reset, entry, run, entry, run
	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_ENTRY = 2'h1,
		ST_RUN = 2'h3
	} eit_state_e;

	// Kind of event being entered
	typedef enum logic [2:0] {
		EK_NONE = 3'h0,
		EK_RESET = 3'h1,
		EK_MISALIGN = 3'h2,
		EK_UNDEF = 3'h3,
		EK_TRAP = 3'h4,
		EK_SBREAK = 3'h5,
		EK_PIRQ = 3'h6,
		EK_RTE = 3'h7
	} eit_kind_e;

	// Processor status bits held by this unit
	typedef struct packed {
		logic sm;
		logic ie;
		logic c;
		logic saved_stack_mode;
		logic saved_int_enable;
		logic bc;
	} eit_psw_s;

	// Vector word of trap n
	function automatic logic [31:0] eit_trap_vec(input logic [3:0] n);
		eit_trap_vec = `EIT_VEC_TRAP_BASE + {`EIT_TRAP_PAD, n, `EIT_WORD_LSB};
	endfunction : eit_trap_vec

	// Status bits to the software-visible word
	function automatic logic [`EIT_PSW_W-1:0] eit_psw_pack(input eit_psw_s p);
		logic [`EIT_PSW_W-1:0] w;
		w = '0;
		w[`EIT_PSW_C] = p.c;
		w[`EIT_PSW_IE] = p.ie;
		w[`EIT_PSW_SM] = p.sm;
		w[`EIT_PSW_BC] = p.bc;
		w[`EIT_PSW_BIE] = p.saved_int_enable;
		w[`EIT_PSW_BSM] = p.saved_stack_mode;
		eit_psw_pack = w;
	endfunction : eit_psw_pack

	// Software-visible word to status bits
	function automatic eit_psw_s eit_psw_unpack(input logic [`EIT_PSW_W-1:0] w);
		eit_psw_s p;
		p.c = w[`EIT_PSW_C];
		p.ie = w[`EIT_PSW_IE];
		p.sm = w[`EIT_PSW_SM];
		p.bc = w[`EIT_PSW_BC];
		p.saved_int_enable = w[`EIT_PSW_BIE];
		p.saved_stack_mode = w[`EIT_PSW_BSM];
		eit_psw_unpack = p;
	endfunction : eit_psw_unpack

endpackage : eit_pkg

// File: hw/eit_sel_if.sv
// Event requests and entry selection passed between the unit's modules
`timescale 1ns/1ps
`default_nettype none
interface eit_sel_if;
	import eit_pkg::*;
	logic misalign;
	logic undef;
	logic trap;
	logic return_from_exception;
	logic sbreak_ok;
	logic pirq_ok;
	logic flash_mode;
	logic [3:0] trap_num;
	logic [31:0] insn_pc;
	logic [31:0] next_pc;
	logic [31:0] saved_pc;
	logic [31:0] vec_addr;
	logic [31:0] save_pc;
	eit_kind_e kind;

	modport top (output misalign, undef, trap, return_from_exception, sbreak_ok, pirq_ok, flash_mode, trap_num,
		insn_pc, next_pc, saved_pc, input kind, vec_addr, save_pc);
	modport arb (input misalign, undef, trap, return_from_exception, sbreak_ok, pirq_ok, output kind);
	modport vec (input kind, trap_num, flash_mode, insn_pc, next_pc, saved_pc, output vec_addr, save_pc);
endinterface : eit_sel_if
`default_nettype wire

// File: hw/eit_arbiter.sv
// Priority selection among the pending events
`timescale 1ns/1ps
`default_nettype none
module eit_arbiter
	import eit_pkg::*;
(
	// Requests in, chosen kind out
	eit_sel_if.arb sel
);

	// Faults first, then trap, return, system break, peripheral request
	always_comb begin
		if (sel.misalign) begin
			sel.kind = EK_MISALIGN;
		end else if (sel.undef) begin
			sel.kind = EK_UNDEF;
		end else if (sel.trap) begin
			sel.kind = EK_TRAP;
		end else if (sel.return_from_exception) begin
			sel.kind = EK_RTE; // Held requests are retaken at the next break
		end else if (sel.sbreak_ok) begin
			sel.kind = EK_SBREAK;
		end else if (sel.pirq_ok) begin
			sel.kind = EK_PIRQ;
		end else begin
			sel.kind = EK_NONE;
		end
	end

endmodule : eit_arbiter
`default_nettype wire

// File: hw/eit_vector.sv
// Vector address and saved pc value for the chosen event
`timescale 1ns/1ps
`default_nettype none
module eit_vector
	import eit_pkg::*;
(
	// Kind and pcs in, target and saved value out
	eit_sel_if.vec sel
);

	// One target and one saved value per kind
	always_comb begin
		sel.vec_addr = `EIT_VEC_RESET;
		sel.save_pc = `EIT_RST_PC;
		case (sel.kind)
			EK_MISALIGN: begin
				sel.vec_addr = `EIT_VEC_MISALIGN;
				sel.save_pc = sel.insn_pc;
			end
			EK_UNDEF: begin
				sel.vec_addr = `EIT_VEC_UNDEF;
				sel.save_pc = sel.insn_pc;
			end
			EK_TRAP: begin
				sel.vec_addr = eit_trap_vec(sel.trap_num);
				sel.save_pc = sel.insn_pc + `EIT_TRAP_STEP;
			end
			EK_SBREAK: begin
				sel.vec_addr = `EIT_VEC_SBREAK;
				sel.save_pc = sel.next_pc;
			end
			EK_PIRQ: begin
				sel.vec_addr = sel.flash_mode ? `EIT_VEC_RAM : `EIT_VEC_PIRQ;
				sel.save_pc = sel.next_pc;
			end
			EK_RTE: begin
				sel.vec_addr = {sel.saved_pc[31:2], `EIT_WORD_LSB};
				sel.save_pc = sel.saved_pc;
			end
			default: begin
				sel.vec_addr = `EIT_VEC_RESET;
				sel.save_pc = `EIT_RST_PC;
			end
		endcase
	end

endmodule : eit_vector
`default_nettype wire

// File: hw/eit_exception_entry.sv
// Exception entry and return sequencer with processor status and saved pc
`timescale 1ns/1ps
`default_nettype none
`include "eit_cfg.svh"

module eit_exception_entry
	import eit_pkg::*;
(
	// Clock, enable and reset
	input wire logic i_mclk,
	input wire logic i_ce,
	input wire logic i_arst_n,
	// Instruction break from the core
	input wire logic i_insn_done,
	input wire logic [31:0] i_insn_pc,
	input wire logic [31:0] i_next_pc,
	input wire logic i_insn_16bit,
	input wire logic i_insn_branch,
	// Event sources
	input wire logic i_misalign_fault,
	input wire logic i_undefined_op_fault,
	input wire logic i_trap,
	input wire logic [3:0] i_trap_num,
	input wire logic i_return_from_exception,
	input wire logic i_system_break,
	input wire logic i_peripheral_irq,
	input wire logic i_flash_ew_mode,
	// Software access to status and saved pc
	input wire logic i_status_wr,
	input wire logic [`EIT_PSW_W-1:0] i_status_wdata,
	input wire logic i_saved_pc_wr,
	input wire logic [31:0] i_saved_pc_wdata,
	input wire logic i_arith_flag_wr,
	input wire logic i_arith_flag_in,
	// Control to the core
	output logic o_cancel,
	output logic o_branch_valid,
	output logic [31:0] o_branch_addr,
	output logic [2:0] o_event_kind,
	// Visible state
	output logic [`EIT_PSW_W-1:0] o_processor_status,
	output logic [31:0] o_saved_pc
);

	logic [1:0] rst_sync_reg;
	logic rst_n;
	eit_state_e state_reg;
	eit_state_e state_next;
	eit_psw_s psw_reg;
	eit_psw_s psw_next;
	logic [31:0] spc_reg;
	logic [31:0] spc_next;
	logic [31:0] addr_reg;
	logic [31:0] addr_next;
	eit_kind_e kind_reg;
	eit_kind_e kind_next;
	logic insn_word_start;
	logic word_break;
	logic take;
	logic take_ce;

	eit_sel_if sel ();

	// Reset release through two flops, first flop read only by the second
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_reg <= `EIT_RST_SYNC;
		end else if (i_ce) begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Break qualification: word boundary, not right after a word-start 16-bit op unless that op branched
	assign insn_word_start = (i_insn_pc[1:0] == `EIT_WORD_LSB);
	assign word_break = i_insn_done && (i_next_pc[1:0] == `EIT_WORD_LSB)
		&& !(i_insn_16bit && insn_word_start && !i_insn_branch);

	// Requests towards the arbiter; the controller has already ranked its sources
	assign sel.misalign = i_insn_done && i_misalign_fault;
	assign sel.undef = i_insn_done && i_undefined_op_fault;
	assign sel.trap = i_insn_done && i_trap;
	assign sel.return_from_exception = i_insn_done && i_return_from_exception;
	assign sel.sbreak_ok = word_break && i_system_break;
	assign sel.pirq_ok = word_break && i_peripheral_irq && psw_reg.ie;
	assign sel.flash_mode = i_flash_ew_mode;
	assign sel.trap_num = i_trap_num;
	assign sel.insn_pc = i_insn_pc;
	assign sel.next_pc = i_next_pc;
	assign sel.saved_pc = spc_reg;

	eit_arbiter u_arbiter (
		.sel(sel.arb)
	);

	eit_vector u_vector (
		.sel(sel.vec)
	);

	// An event is taken only while running; the core stalls during the entry cycle
	assign take = (state_reg == ST_RUN) && (sel.kind != EK_NONE);
	assign take_ce = take && i_ce;

	// Faults cancel the instruction; a cancelled auto-update leaves the base as the core left it
	assign o_cancel = take && ((sel.kind == EK_MISALIGN) || (sel.kind == EK_UNDEF));

	// Next state of the sequencer, status bits, saved pc and branch target
	always_comb begin
		state_next = state_reg;
		psw_next = psw_reg;
		spc_next = spc_reg;
		addr_next = addr_reg;
		kind_next = kind_reg;
		case (state_reg)
			ST_RESET: begin
				addr_next = `EIT_VEC_RESET;
				kind_next = EK_RESET;
				state_next = ST_ENTRY;
			end
			ST_RUN: begin
				// Handler restore of status and saved pc
				if (i_status_wr) begin
					psw_next = eit_psw_unpack(i_status_wdata);
				end
				if (i_arith_flag_wr) begin
					psw_next.c = i_arith_flag_in;
				end
				if (i_saved_pc_wr) begin
					spc_next = i_saved_pc_wdata;
				end
				// Entry overrides the bits it updates; a same-cycle software write keeps the rest, and the saved pc on a return
				if (take) begin
					kind_next = sel.kind;
					addr_next = sel.vec_addr;
					state_next = ST_ENTRY;
					if (sel.kind == EK_RTE) begin
						psw_next.sm = psw_reg.saved_stack_mode;
						psw_next.ie = psw_reg.saved_int_enable;
						psw_next.c = psw_reg.bc;
					end else begin
						psw_next.saved_stack_mode = psw_reg.sm;
						psw_next.saved_int_enable = psw_reg.ie;
						psw_next.bc = psw_reg.c;
						psw_next.ie = 1'b0;
						psw_next.c = 1'b0;
						if ((sel.kind == EK_PIRQ) || (sel.kind == EK_SBREAK)) begin
							psw_next.sm = 1'b0;
						end
						spc_next = sel.save_pc;
					end
				end
			end
			ST_ENTRY: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_RESET;
			end
		endcase
	end

	// Register the sequencer state; frozen while the enable is low
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RESET;
			psw_reg <= '0;
			spc_reg <= `EIT_RST_PC;
			addr_reg <= `EIT_VEC_RESET;
			kind_reg <= EK_NONE;
		end else if (i_ce) begin
			state_reg <= state_next;
			psw_reg <= psw_next;
			spc_reg <= spc_next;
			addr_reg <= addr_next;
			kind_reg <= kind_next;
		end
	end

	// Outputs
	assign o_branch_valid = (state_reg == ST_ENTRY);
	assign o_branch_addr = addr_reg;
	assign o_event_kind = kind_reg;
	assign o_processor_status = eit_psw_pack(psw_reg);
	assign o_saved_pc = spc_reg;

	// Checks on entry, return and priority
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_take_pirq;
		take_ce && (sel.kind == EK_PIRQ);
	endsequence

	sequence s_take_trap;
		take_ce && (sel.kind == EK_TRAP);
	endsequence

	sequence s_entry_then_run;
		o_branch_valid ##1 (!o_branch_valid || !$past(i_ce));
	endsequence

	property p_pirq_gate;
		(take && sel.kind == EK_PIRQ) |-> (psw_reg.ie && (i_next_pc[1:0] == `EIT_WORD_LSB));
	endproperty
	a_pirq_gate: assert property (p_pirq_gate) else $error("peripheral entry without enable or off word");

	property p_no_after_short;
		(i_insn_done && i_insn_16bit && insn_word_start && !i_insn_branch)
			|-> ((sel.kind != EK_PIRQ) && (sel.kind != EK_SBREAK));
	endproperty
	a_no_after_short: assert property (p_no_after_short) else $error("entry after word-start short op");

	property p_backup;
		(take_ce && sel.kind != EK_RTE) |=> ((psw_reg.saved_stack_mode == $past(psw_reg.sm))
			&& (psw_reg.saved_int_enable == $past(psw_reg.ie)) && (psw_reg.bc == $past(psw_reg.c)));
	endproperty
	a_backup: assert property (p_backup) else $error("status backup wrong");

	property p_pirq_clear;
		s_take_pirq |=> (!psw_reg.sm && !psw_reg.ie && !psw_reg.c);
	endproperty
	a_pirq_clear: assert property (p_pirq_clear) else $error("peripheral entry did not clear status");

	property p_trap_keep_sm;
		s_take_trap |=> ((psw_reg.sm == $past(psw_reg.sm)) && !psw_reg.ie && !psw_reg.c);
	endproperty
	a_trap_keep_sm: assert property (p_trap_keep_sm) else $error("trap entry status wrong");

	property p_pirq_target;
		s_take_pirq |=> ((o_saved_pc == $past(i_next_pc))
			&& (o_branch_addr == ($past(i_flash_ew_mode) ? `EIT_VEC_RAM : `EIT_VEC_PIRQ))) and s_entry_then_run;
	endproperty
	a_pirq_target: assert property (p_pirq_target) else $error("peripheral entry target wrong");

	property p_trap_target;
		s_take_trap |=> (o_saved_pc == ($past(i_insn_pc) + `EIT_TRAP_STEP))
			&& (o_branch_addr == eit_trap_vec($past(i_trap_num)))
			&& (o_branch_addr <= `EIT_VEC_TRAP_LAST);
	endproperty
	a_trap_target: assert property (p_trap_target) else $error("trap entry target wrong");

	property p_rte_return;
		(take_ce && sel.kind == EK_RTE) |=> (o_branch_valid && (o_branch_addr[1:0] == `EIT_WORD_LSB)
			&& (o_branch_addr[31:2] == $past(spc_reg[31:2])) && (psw_reg.ie == $past(psw_reg.saved_int_enable)));
	endproperty
	a_rte_return: assert property (p_rte_return) else $error("return target or status wrong");

	property p_priority;
		(i_insn_done && i_misalign_fault) |-> (sel.kind == EK_MISALIGN);
	endproperty
	a_priority: assert property (p_priority) else $error("misalignment not first");

	property p_fault_cancel;
		(take_ce && sel.kind == EK_UNDEF) |-> o_cancel ##1 (o_saved_pc == $past(i_insn_pc));
	endproperty
	a_fault_cancel: assert property (p_fault_cancel) else $error("fault not cancelled or pc wrong");

	property p_sbreak_target;
		(take_ce && sel.kind == EK_SBREAK) |=> (o_branch_addr == `EIT_VEC_SBREAK) && !psw_reg.sm && !o_cancel;
	endproperty
	a_sbreak_target: assert property (p_sbreak_target) else $error("system break target wrong");

endmodule : eit_exception_entry
`default_nettype wire

// File: tb/eit_irq_ctl_model.sv
// Model of the interrupt controller's combined request line towards the entry unit
`timescale 1ns/1ps
`default_nettype none
module eit_irq_ctl_model (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Raise after a delay, withdraw on a vector read or mask write
	input wire logic i_raise,
	input wire logic [3:0] i_delay,
	input wire logic i_ack,
	// Combined request to the unit
	output logic o_irq
);
	logic [4:0] cnt;

	// One ranked request line; a withdrawal wins over a pending raise
	always @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= 5'h00;
			o_irq <= 1'b0;
		end else if (i_ack) begin
			cnt <= 5'h00;
			o_irq <= 1'b0;
		end else if (i_raise) begin
			cnt <= {1'b0, i_delay} + 5'h01;
		end else if (cnt == 5'h01) begin
			cnt <= 5'h00;
			o_irq <= 1'b1;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
		end
	end
endmodule : eit_irq_ctl_model
`default_nettype wire

// File: tb/tb.sv
// Testbench of the exception entry unit: reset, entries, priorities and returns
`timescale 1ns/1ps
`default_nettype none
module tb;
	import eit_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic done = 1'b0, b16 = 1'b0, br = 1'b0, mis = 1'b0, und = 1'b0, trp = 1'b0, return_from_exception = 1'b0, sbrk = 1'b0;
	logic fl = 1'b0, st_wr = 1'b0, spc_wr = 1'b0, c_wr = 1'b0, c_in = 1'b0, raise = 1'b0, ack = 1'b0;
	logic irq, cancel, bv;
	logic ce = 1'b1;
	logic [3:0] num = 4'h0, dly = 4'h0;
	logic [31:0] pc = 32'h0, npc = 32'h0, spc_d = 32'h0, baddr, spc;
	logic [15:0] st_d = 16'h0, st;
	logic [2:0] kind;
	int n_fail = 0, checks_done = 0, cyc = 0;

	// Clock and run limit
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			conclude();
		end
	end

	eit_exception_entry u_dut (.i_mclk(mclk), .i_ce(ce), .i_arst_n(arst_n), .i_insn_done(done),
		.i_insn_pc(pc), .i_next_pc(npc), .i_insn_16bit(b16), .i_insn_branch(br), .i_misalign_fault(mis),
		.i_undefined_op_fault(und), .i_trap(trp), .i_trap_num(num), .i_return_from_exception(return_from_exception),
		.i_system_break(sbrk), .i_peripheral_irq(irq), .i_flash_ew_mode(fl), .i_status_wr(st_wr),
		.i_status_wdata(st_d), .i_saved_pc_wr(spc_wr), .i_saved_pc_wdata(spc_d), .i_arith_flag_wr(c_wr),
		.i_arith_flag_in(c_in), .o_cancel(cancel), .o_branch_valid(bv), .o_branch_addr(baddr),
		.o_event_kind(kind), .o_processor_status(st), .o_saved_pc(spc));

	eit_irq_ctl_model u_icu (.i_mclk(mclk), .i_arst_n(arst_n), .i_raise(raise), .i_delay(dly),
		.i_ack(ack), .o_irq(irq));

	// Verdict and end of run
	task automatic conclude();
		if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude

	// Compare one value
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Software writes, each held for one clock cycle
	task automatic set_st(input logic [15:0] w);
		st_d = w;
		st_wr = 1'b1;
		@(negedge mclk);
		st_wr = 1'b0;
	endtask : set_st

	task automatic set_spc(input logic [31:0] w);
		spc_d = w;
		spc_wr = 1'b1;
		@(negedge mclk);
		spc_wr = 1'b0;
	endtask : set_spc

	task automatic set_c(input logic v);
		c_in = v;
		c_wr = 1'b1;
		@(negedge mclk);
		c_wr = 1'b0;
	endtask : set_c

	// Controller raises its line after a delay; wait for it under a bound
	task automatic irq_up(input logic [3:0] d);
		dly = d;
		raise = 1'b1;
		@(negedge mclk);
		raise = 1'b0;
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(negedge mclk);
	endtask : irq_up

	// One instruction break, entry results one cycle later, then an idle cycle so the unit is back in run
	task automatic brk(input logic [31:0] a, input logic [31:0] na, input logic tk, input logic [2:0] k,
		input logic [31:0] va, input logic [31:0] sp, input logic [15:0] es, input logic [15:0] m, input logic cx);
		pc = a;
		npc = na;
		done = 1'b1;
		#1;
		check("cancel", {31'h0, cancel}, {31'h0, cx});
		@(negedge mclk);
		{done, b16, br, mis, und, trp, return_from_exception, sbrk} = 8'h00;
		check("taken", {31'h0, bv}, {31'h0, tk});
		if (tk) begin
			check("kind", {29'h0, kind}, {29'h0, k});
			check("vector", baddr, va);
			check("saved pc", spc, sp);
			check("status", {16'h0, st & m}, {16'h0, es});
		end
		@(negedge mclk);
	endtask : brk

	// Main sequence
	initial begin
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		for (int i = 0; i < 8 && bv !== 1'b1; i++) @(negedge mclk);
		check("reset kind", {29'h0, kind}, 32'h1);
		check("reset vector", baddr, 32'h0);
		@(negedge mclk);
		// Peripheral entry from a status with stack mode, enable and carry set
		set_st(16'h00c0);
		set_c(1'b1);
		check("status write", {16'h0, st}, 32'h00c1);
		irq_up(4'h3);
		brk(32'h100, 32'h104, 1'b1, 3'h6, 32'h80, 32'h104, 16'hc100, 16'hffff, 1'b0);
		brk(32'h200, 32'h204, 1'b0, 3'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0);
		// Return drops the low pc bits and restores the status bits
		set_spc(32'h20a);
		return_from_exception = 1'b1;
		brk(32'h204, 32'h208, 1'b1, 3'h7, 32'h208, 32'h20a, 16'h00c1, 16'h00c1, 1'b0);
		// Halfword breaks and 16-bit branches
		b16 = 1'b1;
		brk(32'h300, 32'h304, 1'b0, 3'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0);
		b16 = 1'b1;
		br = 1'b1;
		brk(32'h304, 32'h400, 1'b1, 3'h6, 32'h80, 32'h400, 16'hc100, 16'hffff, 1'b0);
		set_st(16'h00c0);
		b16 = 1'b1;
		brk(32'h400, 32'h402, 1'b0, 3'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0);
		fl = 1'b1;
		b16 = 1'b1;
		brk(32'h402, 32'h404, 1'b1, 3'h6, 32'h00804000, 32'h404, 16'hc000, 16'hffff, 1'b0);
		fl = 1'b0;
		ack = 1'b1;
		@(negedge mclk);
		ack = 1'b0;
		set_st(16'h0040);
		brk(32'h500, 32'h504, 1'b0, 3'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0);
		// All sixteen traps, word and halfword placed
		for (int n = 0; n < 16; n++) begin
			set_st({8'h00, n[0], n[1], 5'h00, n[2]});
			trp = 1'b1;
			num = n[3:0];
			brk(32'h600 + 32'(n * 6), 32'h0, 1'b1, 3'h4, 32'h40 + 32'(n * 4), 32'h604 + 32'(n * 6),
				{n[0], n[1], 5'h00, n[2], n[0], 7'h00}, 16'hffff, 1'b0);
		end
		// Coinciding events with the peripheral line up, highest wins
		irq_up(4'h0);
		for (int k = 0; k < 5; k++) begin
			set_st(16'h0041);
			mis = (k == 0);
			und = (k < 2);
			trp = (k < 3);
			num = 4'h5;
			sbrk = (k < 4);
			brk(32'h700, 32'h704, 1'b1, 3'(k + 2), k == 0 ? 32'h30 : k == 1 ? 32'h20 : k == 2 ? 32'h54 : k == 3 ?
				32'h10 : 32'h80, k < 2 ? 32'h700 : k == 2 ? 32'h704 : 32'h704, 16'h4100, 16'hffff,
				k < 2);
		end
		// System break ignores the enable bit and clears stack mode
		set_st(16'h0080);
		sbrk = 1'b1;
		brk(32'h800, 32'h804, 1'b1, 3'h5, 32'h10, 32'h804, 16'h8000, 16'hffff, 1'b0);
		// A low enable freezes the status against a software write
		ce = 1'b0;
		set_st(16'h0000);
		ce = 1'b1;
		check("frozen status", {16'h0, st}, 32'h8000);
		conclude();
	end
endmodule : tb
`default_nettype wire
